// >>> common/tom_pkg.sv
// Functional notes
// - supply ramp: contact may disagree below 20 ms
// - monitor both requests: A blocks PWM, B supply
// - request stops control loop and PWM actuation
// - request drops holding brake actuation output
// - channels must agree within discrepancy time
// - monitoring errors force drive into error state
// - one acknowledge clears all monitoring errors
// - request accepted anytime, even during PWM
// - brake engages only once speed is zero
// - setpoint held off until release delay elapses
// - internal reaction may lag up to 5 ms
// - input A edges remove or apply PWM block
// - input B edges give or remove driver supply
// - compare requests with path feedbacks for plausibility
// - status and errors shown on outputs and bus
// - channels may switch in either order
// - request clears drive enable at once
// - release delay never below brake opening time
// - torque-off only when both off, feedbacks high
// - discrepancy time defaults 100 ms, configurable
// - test pulses of about 4 ms tolerated
package tom_pkg;
   // =============================================
   // timing
   localparam int unsigned CLK_HZ         = 50000000;
   localparam int unsigned TICK_MS_CYC    = CLK_HZ / 1000;
   localparam logic [15:0] DISC_DEF_MS    = 16'h0064;
   localparam logic [15:0] TP_FILT_MS     = 16'h0005;
   localparam logic [15:0] STARTUP_MS     = 16'h000A;
   localparam logic [15:0] PLAUS_MS       = 16'h0014;
   localparam logic [15:0] REL_DEF_MS     = 16'h0064;
   localparam logic [15:0] OPEN_DEF_MS    = 16'h0032;
   // =============================================
   // register map (byte addresses)
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS    = 8'h04;
   localparam logic [7:0]  ADDR_ERRORS    = 8'h08;
   localparam logic [7:0]  ADDR_DISC      = 8'h0C;
   localparam logic [7:0]  ADDR_REL       = 8'h10;
   localparam logic [7:0]  ADDR_OPEN      = 8'h14;
   // =============================================
   // fields
   localparam int unsigned CTRL_ACK_BIT   = 0;
   localparam int unsigned ERR_DISC_BIT   = 0;
   localparam int unsigned ERR_PLA_BIT    = 1;
   localparam int unsigned ERR_PLB_BIT    = 2;
   localparam int unsigned NUM_IN         = 6;
   localparam logic [1:0]  AXI_OKAY       = 2'h0;
   localparam logic [1:0]  AXI_SLVERR     = 2'h2;
   typedef enum logic [1:0] {
      ST_STARTUP,
      ST_IDLE,
      ST_RELEASE,
      ST_RUN
   } tom_state_type;
endpackage

// >>> logic/tom_top.sv
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tom_top
   import tom_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_MS_CYC
) (
   input  wire logic        CLK_I,
   input  wire logic        NRST_I,
   input  wire logic        REQUEST_INPUT_A_I,
   input  wire logic        REQUEST_INPUT_B_I,
   input  wire logic        PATH_FB_A_I,
   input  wire logic        PATH_FB_B_I,
   input  wire logic        DRIVE_ENABLE_INPUT_I,
   input  wire logic        SPEED_ZERO_I,
   output logic             PWM_BLOCK_O,
   output logic             DRIVER_SUPPLY_EN_O,
   output logic             CONTROL_EN_O,
   output logic             BRAKE_RELEASE_O,
   output logic             SETPOINT_EN_O,
   output logic             FEEDBACK_CONTACT_O,
   output logic             TORQUE_OFF_O,
   output logic             ERROR_O,
   input  wire logic [7:0]  AWADDR_I,
   input  wire logic        AWVALID_I,
   output logic             AWREADY_O,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  WSTRB_I,
   input  wire logic        WVALID_I,
   output logic             WREADY_O,
   output logic [1:0]       BRESP_O,
   output logic             BVALID_O,
   input  wire logic        BREADY_I,
   input  wire logic [7:0]  ARADDR_I,
   input  wire logic        ARVALID_I,
   output logic             ARREADY_O,
   output logic [31:0]      RDATA_O,
   output logic [1:0]       RRESP_O,
   output logic             RVALID_O,
   input  wire logic        RREADY_I
);
   // =============================================
   // input synchronisers
   logic [NUM_IN-1:0] raw_in;
   logic [NUM_IN-1:0] meta_r;
   logic [NUM_IN-1:0] sync_r;
   assign raw_in = {SPEED_ZERO_I, DRIVE_ENABLE_INPUT_I, PATH_FB_B_I, PATH_FB_A_I,
                    REQUEST_INPUT_B_I, REQUEST_INPUT_A_I};
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
         always_ff @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
               meta_r[gi] <= 1'b0;
               sync_r[gi] <= 1'b0;
            end else begin
               meta_r[gi] <= raw_in[gi];
               sync_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate
   logic req_a_s, req_b_s, fb_a_s, fb_b_s, en_s, spd0_s;
   assign req_a_s = sync_r[0];
   assign req_b_s = sync_r[1];
   assign fb_a_s  = sync_r[2];
   assign fb_b_s  = sync_r[3];
   assign en_s    = sync_r[4];
   assign spd0_s  = sync_r[5];

   // =============================================
   // millisecond tick
   logic [31:0] tick_cnt_r;
   logic        tick_r;
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         tick_cnt_r <= 32'h0;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
         tick_cnt_r <= 32'h0;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
         tick_r     <= 1'b0;
      end
   end

   // =============================================
   // test pulse filter, falling edges only
   // rising edges pass at once; a low must outlast the pulse window
   logic [1:0]  req_s;
   logic [1:0]  filt_r;
   logic [15:0] lowcnt_r [2];
   assign req_s = {req_b_s, req_a_s};
   generate
      for (gi = 0; gi < 2; gi++) begin : g_filt
         always_ff @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
               filt_r[gi]   <= 1'b0;
               lowcnt_r[gi] <= 16'h0;
            end else if (req_s[gi]) begin
               filt_r[gi]   <= 1'b1;
               lowcnt_r[gi] <= 16'h0;
            end else if (lowcnt_r[gi] >= TP_FILT_MS) begin
               filt_r[gi]   <= 1'b0;
            end else if (tick_r) begin
               lowcnt_r[gi] <= lowcnt_r[gi] + 16'h1;
            end
         end
      end
   endgenerate
   logic run_a, run_b, request;
   assign run_a   = filt_r[0];
   assign run_b   = filt_r[1];
   // either channel dropping is a request, whatever the order
   assign request = ~run_a | ~run_b;

   // =============================================
   // configuration registers and errors
   logic [15:0] disc_ms_r;
   logic [15:0] rel_ms_r;
   logic [15:0] open_ms_r;
   logic        err_disc_r;
   logic        err_pla_r;
   logic        err_plb_r;
   logic        ack_pulse;
   logic        any_err;
   assign any_err = err_disc_r | err_pla_r | err_plb_r;

   // =============================================
   // discrepancy monitor
   logic [15:0] disc_cnt_r;
   logic        disc_over;
   assign disc_over = (run_a != run_b) && (disc_cnt_r >= disc_ms_r);
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         disc_cnt_r <= 16'h0;
      end else if (run_a == run_b) begin
         disc_cnt_r <= 16'h0;
      end else if (tick_r && !disc_over) begin
         disc_cnt_r <= disc_cnt_r + 16'h1;
      end
   end
   // set wins over acknowledge
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         err_disc_r <= 1'b0;
      end else if (disc_over) begin
         err_disc_r <= 1'b1;
      end else if (ack_pulse) begin
         err_disc_r <= 1'b0;
      end
   end

   // =============================================
   // plausibility of disconnection paths
   // feedback reads 1 when a path is off; allow switching time first
   logic [1:0]  fb_s;
   logic [1:0]  pl_bad;
   logic [15:0] pl_cnt_r [2];
   logic [1:0]  pl_over;
   assign fb_s = {fb_b_s, fb_a_s};
   generate
      for (gi = 0; gi < 2; gi++) begin : g_plaus
         assign pl_bad[gi]  = (fb_s[gi] == filt_r[gi]);
         assign pl_over[gi] = pl_bad[gi] && (pl_cnt_r[gi] >= PLAUS_MS);
         always_ff @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
               pl_cnt_r[gi] <= 16'h0;
            end else if (!pl_bad[gi]) begin
               pl_cnt_r[gi] <= 16'h0;
            end else if (tick_r && !pl_over[gi]) begin
               pl_cnt_r[gi] <= pl_cnt_r[gi] + 16'h1;
            end
         end
      end
   endgenerate
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         err_pla_r <= 1'b0;
         err_plb_r <= 1'b0;
      end else begin
         err_pla_r <= pl_over[0] | (err_pla_r & ~ack_pulse);
         err_plb_r <= pl_over[1] | (err_plb_r & ~ack_pulse);
      end
   end

   // =============================================
   // drive sequencer
   tom_state_type state_r;
   logic [15:0]   seq_cnt_r;
   logic [15:0]   rel_eff;
   logic          stop_cond;
   // release delay is floored at the brake opening time
   assign rel_eff   = (rel_ms_r > open_ms_r) ? rel_ms_r : open_ms_r;
   assign stop_cond = request | ~en_s | any_err;
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_r   <= ST_STARTUP;
         seq_cnt_r <= 16'h0;
      end else begin
         unique case (state_r)
            ST_STARTUP: begin
               // hold everything open while supplies settle
               if (seq_cnt_r >= STARTUP_MS) begin
                  state_r   <= ST_IDLE;
                  seq_cnt_r <= 16'h0;
               end else if (tick_r) begin
                  seq_cnt_r <= seq_cnt_r + 16'h1;
               end
            end
            ST_IDLE: begin
               seq_cnt_r <= 16'h0;
               if (!stop_cond) begin
                  state_r <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               if (stop_cond) begin
                  state_r <= ST_IDLE;
               end else if (seq_cnt_r >= rel_eff) begin
                  state_r <= ST_RUN;
               end else if (tick_r) begin
                  seq_cnt_r <= seq_cnt_r + 16'h1;
               end
            end
            ST_RUN: begin
               if (stop_cond) begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // =============================================
   // actuation outputs
   logic active;
   assign active = (state_r == ST_RELEASE) || (state_r == ST_RUN);
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         CONTROL_EN_O  <= 1'b0;
         SETPOINT_EN_O <= 1'b0;
         PWM_BLOCK_O   <= 1'b1;
      end else begin
         CONTROL_EN_O  <= active & ~stop_cond;
         SETPOINT_EN_O <= (state_r == ST_RUN) & ~stop_cond;
         PWM_BLOCK_O   <= ~run_a | ~active | stop_cond;
      end
   end
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         DRIVER_SUPPLY_EN_O <= 1'b0;
      end else begin
         DRIVER_SUPPLY_EN_O <= run_b & (state_r != ST_STARTUP);
      end
   end
   // brake drops only at standstill, so a coasting load is not gripped
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         BRAKE_RELEASE_O <= 1'b0;
      end else if (active && !stop_cond) begin
         BRAKE_RELEASE_O <= 1'b1;
      end else if (spd0_s) begin
         BRAKE_RELEASE_O <= 1'b0;
      end
   end

   // =============================================
   // status outputs
   logic sto_state;
   assign sto_state = ~run_a & ~run_b & fb_a_s & fb_b_s;
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         FEEDBACK_CONTACT_O <= 1'b0;
         TORQUE_OFF_O       <= 1'b0;
         ERROR_O            <= 1'b0;
      end else begin
         FEEDBACK_CONTACT_O <= sto_state & (state_r != ST_STARTUP);
         TORQUE_OFF_O       <= sto_state;
         ERROR_O            <= any_err;
      end
   end

   // =============================================
   // axi4-lite write channel
   logic       aw_got_r, w_got_r, do_wr;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic       aw_hs, w_hs, aw_got_nxt, w_got_nxt, bvalid_nxt;
   assign aw_hs      = AWVALID_I & AWREADY_O;
   assign w_hs       = WVALID_I & WREADY_O;
   assign do_wr      = aw_got_r & w_got_r & ~BVALID_O;
   assign aw_got_nxt = (aw_got_r | aw_hs) & ~do_wr;
   assign w_got_nxt  = (w_got_r | w_hs) & ~do_wr;
   assign bvalid_nxt = (BVALID_O & ~BREADY_I) | do_wr;
   assign ack_pulse  = do_wr && (awaddr_r == ADDR_CTRL) && wstrb_r[0]
                       && wdata_r[CTRL_ACK_BIT];
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
         AWREADY_O <= 1'b0;
         WREADY_O  <= 1'b0;
         BVALID_O  <= 1'b0;
         BRESP_O   <= AXI_OKAY;
      end else begin
         aw_got_r  <= aw_got_nxt;
         w_got_r   <= w_got_nxt;
         AWREADY_O <= ~aw_got_nxt & ~bvalid_nxt;
         WREADY_O  <= ~w_got_nxt & ~bvalid_nxt;
         BVALID_O  <= bvalid_nxt;
         if (aw_hs) begin
            awaddr_r <= AWADDR_I;
         end
         if (w_hs) begin
            wdata_r <= WDATA_I;
            wstrb_r <= WSTRB_I;
         end
         if (do_wr) begin
            BRESP_O <= (awaddr_r > ADDR_OPEN || awaddr_r[1:0] != 2'h0 ||
                        awaddr_r == ADDR_STATUS || awaddr_r == ADDR_ERRORS)
                       ? AXI_SLVERR : AXI_OKAY;
         end
      end
   end
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         disc_ms_r <= DISC_DEF_MS;
         rel_ms_r  <= REL_DEF_MS;
         open_ms_r <= OPEN_DEF_MS;
      end else if (do_wr) begin
         for (int b = 0; b < 2; b++) begin
            if (wstrb_r[b]) begin
               if (awaddr_r == ADDR_DISC) disc_ms_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
               if (awaddr_r == ADDR_REL)  rel_ms_r[b*8 +: 8]  <= wdata_r[b*8 +: 8];
               if (awaddr_r == ADDR_OPEN) open_ms_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
            end
         end
      end
   end

   // =============================================
   // axi4-lite read channel
   logic [31:0] rd_mux;
   logic        rd_ok;
   always_comb begin
      rd_mux = 32'h0;
      rd_ok  = 1'b1;
      unique case (ARADDR_I)
         ADDR_CTRL:   rd_mux = 32'h0;
         ADDR_STATUS: rd_mux = {16'h0, 4'h0, 2'(state_r), sto_state, BRAKE_RELEASE_O,
                                spd0_s, en_s, fb_b_s, fb_a_s, run_b, run_a,
                                req_b_s, req_a_s};
         ADDR_ERRORS: rd_mux = {29'h0, err_plb_r, err_pla_r, err_disc_r};
         ADDR_DISC:   rd_mux = {16'h0, disc_ms_r};
         ADDR_REL:    rd_mux = {16'h0, rel_ms_r};
         ADDR_OPEN:   rd_mux = {16'h0, open_ms_r};
         default:     rd_ok  = 1'b0;
      endcase
   end
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ARREADY_O <= 1'b0;
         RVALID_O  <= 1'b0;
         RDATA_O   <= 32'h0;
         RRESP_O   <= AXI_OKAY;
      end else if (ARVALID_I && ARREADY_O) begin
         ARREADY_O <= 1'b0;
         RVALID_O  <= 1'b1;
         RDATA_O   <= rd_mux;
         RRESP_O   <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (RVALID_O && RREADY_I) begin
         RVALID_O  <= 1'b0;
      end else begin
         ARREADY_O <= ~RVALID_O;
      end
   end
endmodule

// >>> test/tom_top_properties.sv
`timescale 1ns/1ps
// ==========================================
// port-level checks of the monitor
module tom_properties
   import tom_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 10
) (
   input wire logic        CLK_I,
   input wire logic        NRST_I,
   input wire logic        REQUEST_INPUT_A_I,
   input wire logic        REQUEST_INPUT_B_I,
   input wire logic        SPEED_ZERO_I,
   input wire logic        WVALID_I,
   input wire logic        WREADY_O,
   input wire logic        BREADY_I,
   input wire logic        RREADY_I,
   input wire logic        PWM_BLOCK_O,
   input wire logic        DRIVER_SUPPLY_EN_O,
   input wire logic        CONTROL_EN_O,
   input wire logic        BRAKE_RELEASE_O,
   input wire logic        SETPOINT_EN_O,
   input wire logic        FEEDBACK_CONTACT_O,
   input wire logic        ERROR_O,
   input wire logic [1:0]  BRESP_O,
   input wire logic        BVALID_O,
   input wire logic [31:0] RDATA_O,
   input wire logic        RVALID_O
);
   // 5 ms filter, 1 ms tick slack, sync stages
   localparam int unsigned LIM = 7 * TICK_CYCLES;
   int unsigned lo_a_r, lo_b_r, w_age_r;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   // ==========================================
   // helper counters
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) lo_a_r <= 32'h0;
      else if (REQUEST_INPUT_A_I) lo_a_r <= 32'h0;
      else if (lo_a_r < LIM) lo_a_r <= lo_a_r + 32'h1;
   end
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) lo_b_r <= 32'h0;
      else if (REQUEST_INPUT_B_I) lo_b_r <= 32'h0;
      else if (lo_b_r < LIM) lo_b_r <= lo_b_r + 32'h1;
   end
   // saturates so an old write never looks fresh
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) w_age_r <= 32'hF;
      else if (WVALID_I && WREADY_O) w_age_r <= 32'h0;
      else if (w_age_r < 32'hF) w_age_r <= w_age_r + 32'h1;
   end
   // ==========================================
   // assertions
   chk_contact_safe: assert property (
      FEEDBACK_CONTACT_O |-> PWM_BLOCK_O && !CONTROL_EN_O && !SETPOINT_EN_O)
      else $error("contact closed while drive active");
   chk_stop_on_a: assert property (
      lo_a_r >= LIM |-> PWM_BLOCK_O && !CONTROL_EN_O && !SETPOINT_EN_O)
      else $error("channel A request did not stop drive");
   chk_stop_on_b: assert property (
      lo_b_r >= LIM |-> !DRIVER_SUPPLY_EN_O && !CONTROL_EN_O)
      else $error("channel B request left supply on");
   chk_brake_speed: assert property (
      $fell(BRAKE_RELEASE_O) |-> $past(SPEED_ZERO_I, 3))
      else $error("brake engaged while moving");
   chk_setpoint_wait: assert property (
      $rose(SETPOINT_EN_O) |-> CONTROL_EN_O && $past(BRAKE_RELEASE_O, 8))
      else $error("setpoint enabled before brake delay");
   chk_ack_clears: assert property (
      $fell(ERROR_O) |-> w_age_r <= 32'h4)
      else $error("error cleared without acknowledge");
   chk_error_stops: assert property (
      ERROR_O [*3] |-> !CONTROL_EN_O && !SETPOINT_EN_O)
      else $error("drive runs with error");
   chk_bresp_hold: assert property (
      BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
      else $error("write response dropped early");
   chk_rdata_hold: assert property (
      RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read data dropped early");
   cov_contact: cover property ($rose(FEEDBACK_CONTACT_O));
   cov_error: cover property ($rose(ERROR_O));
   cov_setpoint: cover property ($rose(SETPOINT_EN_O));
endmodule
bind tom_top tom_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);

// >>> test/tom_safety_relay.sv
`timescale 1ns/1ps
// ==========================================
// far side: two-channel relay and path feedback
module tom_safety_relay (
   input  wire logic       clk_i,
   input  wire logic       run_i,
   input  wire logic [7:0] dla_i,
   input  wire logic [7:0] dlb_i,
   input  wire logic       pulse_i,
   input  wire logic       fault_i,
   output logic            req_a_o,
   output logic            req_b_o,
   output logic            fb_a_o,
   output logic            fb_b_o
);
   logic [7:0] ca_r = 8'h00, cb_r = 8'h00;
   logic       qa_r = 1'b0, qb_r = 1'b0;
   logic [2:0] fa_r = 3'h7, fb_r = 3'h7;
   // own delay per channel, so either may lead
   always_ff @(posedge clk_i) begin
      ca_r <= (qa_r == run_i) ? 8'h00 : ca_r + 8'h01;
      cb_r <= (qb_r == run_i) ? 8'h00 : cb_r + 8'h01;
      if (qa_r != run_i && ca_r >= dla_i) qa_r <= run_i;
      if (qb_r != run_i && cb_r >= dlb_i) qb_r <= run_i;
   end
   assign req_a_o = qa_r & ~pulse_i;
   assign req_b_o = qb_r;
   // path reads 1 when blocked, a few cycles late; fault sticks A
   always_ff @(posedge clk_i) begin
      fa_r <= {fa_r[1:0], ~req_a_o};
      fb_r <= {fb_r[1:0], ~req_b_o};
   end
   assign fb_a_o = fa_r[2] | fault_i;
   assign fb_b_o = fb_r[2];
endmodule

// >>> test/tom_top_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// bench top
module tom_top_tb_top;
   import tom_pkg::*;
   localparam int unsigned TK = 10;
   logic        clk = 1'b0, nrst = 1'b0, en = 1'b0, spd = 1'b1, run = 1'b0;
   logic        pls = 1'b0, flt = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
   logic        arv = 1'b0, rry = 1'b0;
   logic [7:0]  dla = 8'h00, dlb = 8'h00, awa = 8'h00, ara = 8'h00;
   logic [3:0]  ws = 4'hF;
   logic [31:0] wd = 32'h0, cd;
   logic [1:0]  cr;
   wire  [7:0]  o;
   wire         ra, rb, fa, fb, awr, wrd, bv, arr, rv;
   wire  [1:0]  br, rr;
   wire  [31:0] rdt;
   wire  [2:0]  hv = {rv, bv, arr};
   int          mismatches = 0, n_compared = 0, seed = 32'hF11B9FCC;
   int unsigned rm [logic [7:0]];
   string       nm [8] = '{"pwm_block", "supply", "control", "brake", "setpoint",
                           "contact", "torque_off", "error"};
   always #10 clk = ~clk;
   tom_top #(.TICK_CYCLES(TK)) dut (.CLK_I(clk), .NRST_I(nrst),
      .REQUEST_INPUT_A_I(ra), .REQUEST_INPUT_B_I(rb), .PATH_FB_A_I(fa), .PATH_FB_B_I(fb),
      .DRIVE_ENABLE_INPUT_I(en), .SPEED_ZERO_I(spd), .PWM_BLOCK_O(o[0]),
      .DRIVER_SUPPLY_EN_O(o[1]), .CONTROL_EN_O(o[2]), .BRAKE_RELEASE_O(o[3]),
      .SETPOINT_EN_O(o[4]), .FEEDBACK_CONTACT_O(o[5]), .TORQUE_OFF_O(o[6]), .ERROR_O(o[7]),
      .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(ws),
      .WVALID_I(wv), .WREADY_O(wrd), .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bry),
      .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdt), .RRESP_O(rr),
      .RVALID_O(rv), .RREADY_I(rry));
   tom_safety_relay u_relay (.clk_i(clk), .run_i(run), .dla_i(dla), .dlb_i(dlb),
      .pulse_i(pls), .fault_i(flt), .req_a_o(ra), .req_b_o(rb), .fb_a_o(fa), .fb_b_o(fb));
   // ==========================================
   // report and compare
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic tmo;
      mismatches++;
      $display("ERROR handshake expected done seen timeout");
      end_of_test();
   endtask
   task automatic cmp_lvl(input string n, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // bounded wait for an output level, then compare it
   task automatic wait_o(input int k, input logic v, input int lim);
      for (int n = 0; n < lim && o[k] !== v; n++) @(negedge clk);
      cmp_lvl(nm[k], v, o[k]);
      // a wait that ran out ends the run at once
      if (o[k] !== v) end_of_test();
   endtask
   // ready or valid sampled mid-cycle, so the release lands on the edge it counts at
   task automatic hs(input int k);
      logic t;
      t = 1'b0;
      for (int n = 0; !t; n++) begin
         if (n == 40) tmo();
         @(negedge clk);
         t = hv[k];
         cd = rdt;
         cr = (k == 1) ? br : rr;
         @(posedge clk);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, da, dw;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      da = 1'b0;
      dw = 1'b0;
      for (int n = 0; !(da && dw); n++) begin
         if (n == 40) tmo();
         @(negedge clk);
         ta = awr & ~da;
         tw = wrd & ~dw;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         da = da | ta;
         dw = dw | tw;
      end
      // late ready lets the response wait on the master
      cyc(2);
      bry <= 1'b1;
      hs(1);
      bry <= 1'b0;
      cmp_word("write resp", {30'h0, er}, {30'h0, cr});
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      hs(0);
      arv <= 1'b0;
      cyc(1);
      rry <= 1'b1;
      hs(2);
      rry <= 1'b0;
      cmp_word("read data", ed, cd);
      cmp_word("read resp", {30'h0, er}, {30'h0, cr});
   endtask
   // ==========================================
   // main sequence
   initial begin
      rm[ADDR_DISC] = DISC_DEF_MS;
      rm[ADDR_REL] = REL_DEF_MS;
      rm[ADDR_OPEN] = OPEN_DEF_MS;
      cyc(2);
      nrst <= 1'b1;
      cyc(2);
      foreach (rm[a]) axr(a, rm[a], AXI_OKAY);
      rm[ADDR_DISC] = 3;
      rm[ADDR_REL] = 1;
      rm[ADDR_OPEN] = 4;
      foreach (rm[a]) begin
         axw(a, rm[a], AXI_OKAY);
         axr(a, rm[a], AXI_OKAY);
      end
      axr(8'h20, 32'h0, AXI_SLVERR);
      axw(ADDR_STATUS, 32'h3, AXI_SLVERR);
      $display("registers done");
      cyc(100);
      wait_o(5, 1'b1, 30);
      cmp_lvl(nm[6], 1'b1, o[6]);
      dla <= 8'($random(seed) & 7);
      dlb <= 8'($random(seed) & 7);
      run <= 1'b1;
      wait_o(5, 1'b0, 80);
      cyc(60);
      en <= 1'b1;
      spd <= 1'b0;
      wait_o(2, 1'b1, 20);
      cmp_lvl(nm[3], 1'b1, o[3]);
      cyc(25);
      cmp_lvl(nm[4], 1'b0, o[4]);
      wait_o(4, 1'b1, 60);
      cmp_lvl(nm[0], 1'b0, o[0]);
      cmp_lvl(nm[1], 1'b1, o[1]);
      $display("restart done");
      pls <= 1'b1;
      cyc(10 + ($random(seed) & 15));
      pls <= 1'b0;
      cyc(80);
      cmp_lvl(nm[2], 1'b1, o[2]);
      cmp_lvl(nm[7], 1'b0, o[7]);
      $display("test pulse done");
      dla <= 8'($random(seed) & 7);
      dlb <= 8'($random(seed) & 7);
      run <= 1'b0;
      wait_o(2, 1'b0, 100);
      cmp_lvl(nm[0], 1'b1, o[0]);
      cmp_lvl(nm[4], 1'b0, o[4]);
      wait_o(1, 1'b0, 20);
      cyc(20);
      cmp_lvl(nm[3], 1'b1, o[3]);
      spd <= 1'b1;
      wait_o(3, 1'b0, 10);
      wait_o(5, 1'b1, 20);
      cmp_lvl(nm[6], 1'b1, o[6]);
      cmp_lvl(nm[7], 1'b0, o[7]);
      $display("request done");
      en <= 1'b0;
      dlb <= 8'hFF;
      run <= 1'b1;
      wait_o(7, 1'b1, 80);
      axr(ADDR_ERRORS, 32'h1, AXI_OKAY);
      cyc(320);
      en <= 1'b1;
      flt <= 1'b1;
      cyc(260);
      flt <= 1'b0;
      cmp_lvl(nm[2], 1'b0, o[2]);
      axr(ADDR_ERRORS, 32'h7 & 32'h3, AXI_OKAY);
      en <= 1'b0;
      // acknowledge without the low byte strobe must not clear
      ws <= 4'hE;
      axw(ADDR_CTRL, 32'h1, AXI_OKAY);
      ws <= 4'hF;
      axr(ADDR_ERRORS, 32'h3, AXI_OKAY);
      axw(ADDR_CTRL, 32'h1, AXI_OKAY);
      wait_o(7, 1'b0, 5);
      axr(ADDR_ERRORS, 32'h0, AXI_OKAY);
      $display("errors done");
      nrst <= 1'b0;
      cyc(2);
      cmp_lvl(nm[0], 1'b1, o[0]);
      cmp_lvl(nm[2], 1'b0, o[2]);
      nrst <= 1'b1;
      cyc(2);
      axr(ADDR_DISC, 32'h64, AXI_OKAY);
      $display("second reset done");
      end_of_test();
   end
endmodule
